// ==== raw_align_pkg.sv ====
`default_nettype none
// ============================================================
// shared constants and types for the stall and alignment block
// ============================================================
package raw_align_pkg;

    // ============================================================
    // widths
    // ============================================================
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned WREG_IDX_W = 4;
    localparam int unsigned LANES = 2;

    // ============================================================
    // working register map
    // ============================================================
    // each working register is mirrored in data space at index * 2
    localparam logic [15:0] WREG_MAP_BASE = 16'h0000;
    localparam logic [3:0] STACK_PTR_IDX = 4'hF;
    localparam logic [15:0] BYTE_ZERO_HI = 16'h00FF;

    // ============================================================
    // timing
    // ============================================================
    // the stall lasts exactly this many instruction cycles
    localparam int unsigned STALL_CYCLES = 1;

    // ============================================================
    // effective address modes of an operand
    // ============================================================
    typedef enum logic [1:0] {
        AM_NONE,
        AM_DIRECT,
        AM_INDIRECT,
        AM_INDIRECT_MOD
    } addr_mode_t;

    // ============================================================
    // data access sizes
    // ============================================================
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_DWORD
    } acc_size_t;

endpackage
`default_nettype wire

// ==== byte_lane_steer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// little-endian byte lane steering for the data port
// ============================================================
module byte_lane_steer (
    // access being issued
    input wire raw_align_pkg::acc_size_t size,
    input wire logic addr_lsb,
    input wire logic [15:0] wdata,
    output logic [1:0] be,
    output logic [15:0] lane_wdata,
    // read return
    input wire logic rd_byte,
    input wire logic rd_hi,
    input wire logic [15:0] mem_rdata,
    output logic [15:0] rdata
);

    // ============================================================
    // byte enables, one per lane
    // ============================================================
    // lane 0 is the even address, lane 1 the odd one
    for (genvar i = 0; i < raw_align_pkg::LANES; i++) begin : g_lane
        assign be[i] = (size != raw_align_pkg::SZ_BYTE) || (addr_lsb == 1'(i));
    end

    // ============================================================
    // write and read data placement
    // ============================================================
    // a byte write puts its data on both lanes; the enable picks one
    always_comb begin
        if (size == raw_align_pkg::SZ_BYTE) begin
            lane_wdata = {wdata[7:0], wdata[7:0]};
        end else begin
            lane_wdata = wdata;
        end
    end

    // a byte read returns the selected lane in the low byte, zero above
    always_comb begin
        if (rd_byte) begin
            rdata = {8'h00, (rd_hi ? mem_rdata[15:8] : mem_rdata[7:0])};
        end else begin
            rdata = mem_rdata;
        end
    end

endmodule
`default_nettype wire

// ==== raw_stall_align.sv ====
`timescale 1ns/1ps
`default_nettype none
// Contract
// - at pre-decode, check for an address register dependency across the boundary
// - compare executing destination EA register with pre-fetched source EA register
// - a needed stall delays execution by exactly one instruction cycle
// - on match, mode pair decides; direct source never stalls, written pointer does
// - indirect then indirect stalls only if register holds its own mapped address
// - a stall right before exception processing is still inserted
// - call and relative call write the stack pointer; indirect use of it stalls
// - jump, return and return from interrupt never cause a stall
// - loops change nothing: same detection on entry, exit and every pass
// - dependency after a window access starts the stall in its second cycle
// - dependency before a window access stalls in the prior instruction's last cycle
// - byte mode direct register write changes only the low byte
// - byte mode indirect operand reaches the single byte at the pointer address
// - byte mode file register operand reaches the single addressed byte
// - byte mode status flags come from the 8-bit result
// - addresses are byte addresses; words are little-endian, low byte even
// - odd word access raises address error, taken after the instruction ends
// - misaligned word read clears address bit 0, completes and flags error
// - misaligned word write is suppressed and flags error
module raw_stall_align (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // executing instruction
    input wire logic ex_dst_valid,
    input wire logic [3:0] ex_dst_reg,
    input wire raw_align_pkg::addr_mode_t ex_dst_mode,
    input wire logic ex_is_call,
    input wire logic ex_no_wreg_write,
    input wire logic ex_last_cycle,
    input wire logic ex_is_window,
    input wire logic ex_window_second,
    input wire logic exc_pending,
    // pre-fetched instruction
    input wire logic pf_src_valid,
    input wire logic [3:0] pf_src_reg,
    input wire raw_align_pkg::addr_mode_t pf_src_mode,
    input wire logic [15:0] pf_src_reg_value,
    // pipeline hold
    output logic stall_q,
    output logic hold_pc_q,
    output logic hold_prefetch_q,
    // data access request
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire raw_align_pkg::acc_size_t acc_size,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    // x data memory
    output logic [15:0] mem_addr_q,
    output logic [1:0] mem_be_q,
    output logic mem_we_q,
    output logic mem_re_q,
    output logic [15:0] mem_wdata_q,
    input wire logic [15:0] mem_rdata,
    // read return and error
    output logic [15:0] rdata_q,
    output logic rdata_valid_q,
    output logic addr_err_q,
    // working register write-back
    input wire logic reg_wr_valid,
    input wire logic reg_byte,
    input wire logic [15:0] reg_old,
    input wire logic [15:0] reg_result,
    output logic reg_we_q,
    output logic [15:0] reg_wdata_q,
    // status flags
    input wire logic alu_valid,
    input wire logic alu_byte,
    input wire logic [15:0] alu_result,
    output logic flag_n_q,
    output logic flag_z_q
);

    // ============================================================
    // state
    // ============================================================
    typedef struct packed {
        logic stall;
        logic [15:0] mem_addr;
        logic [1:0] mem_be;
        logic mem_we;
        logic mem_re;
        logic [15:0] mem_wdata;
        logic rd_hi;
        logic rd_byte;
        logic [15:0] rdata;
        logic rdata_valid;
        logic addr_err;
        logic reg_we;
        logic [15:0] reg_wdata;
        logic flag_n;
        logic flag_z;
    } state_t;

    localparam state_t STATE_RESET = '0;

    state_t s_q;
    state_t s_d;

    // ============================================================
    // decode helpers
    // ============================================================
    // pointer use of a register, with or without modification
    function automatic logic is_indirect(input raw_align_pkg::addr_mode_t m);
        is_indirect = (m == raw_align_pkg::AM_INDIRECT) ||
                      (m == raw_align_pkg::AM_INDIRECT_MOD);
    endfunction

    // data space address at which a working register is mirrored
    function automatic logic [15:0] wreg_map_addr(input logic [3:0] r);
        wreg_map_addr = raw_align_pkg::WREG_MAP_BASE + {11'h000, r, 1'b0};
    endfunction

    // mode pair decision once the two registers match
    function automatic logic pair_stalls(
        input raw_align_pkg::addr_mode_t dm,
        input raw_align_pkg::addr_mode_t sm,
        input logic [15:0] val,
        input logic [3:0] r
    );
        pair_stalls = 1'b0;
        if (is_indirect(sm)) begin
            case (dm)
                raw_align_pkg::AM_DIRECT: pair_stalls = 1'b1;
                raw_align_pkg::AM_INDIRECT_MOD: pair_stalls = 1'b1;
                // plain indirect only clashes through the register's own mirror
                raw_align_pkg::AM_INDIRECT: pair_stalls = (val == wreg_map_addr(r));
                default: pair_stalls = 1'b0;
            endcase
        end
    endfunction

    // ============================================================
    // hazard detection
    // ============================================================
    logic detect_point;
    logic dst_live;
    raw_align_pkg::addr_mode_t eff_dst_mode;
    logic [3:0] eff_dst_reg;
    logic hazard;

    // a window access decides in its second cycle, everything else in its
    // last cycle; the last cycle also covers the instruction ahead of a window
    // access, so that stall lands before the window access begins
    assign detect_point = ex_is_window ? ex_window_second : ex_last_cycle;

    // a call pushes through the stack pointer with post-increment
    always_comb begin
        if (ex_is_call) begin
            eff_dst_mode = raw_align_pkg::AM_INDIRECT_MOD;
            eff_dst_reg = raw_align_pkg::STACK_PTR_IDX;
        end else begin
            eff_dst_mode = ex_dst_mode;
            eff_dst_reg = ex_dst_reg;
        end
    end

    // jump and return flavours write no working register
    assign dst_live = (ex_dst_valid || ex_is_call) && !ex_no_wreg_write;

    // loop state and pending exceptions deliberately do not gate this
    // term, so stall timing is identical everywhere
    assign hazard = detect_point && !s_q.stall && dst_live && pf_src_valid
                    && (eff_dst_reg == pf_src_reg)
                    && pair_stalls(eff_dst_mode, pf_src_mode, pf_src_reg_value, pf_src_reg);

    // ============================================================
    // access checks and lane steering
    // ============================================================
    logic misalign;
    logic rd_go;
    logic wr_go;
    logic [1:0] lane_be;
    logic [15:0] lane_wdata;
    logic [15:0] rd_sel;

    // word and double word need an even address; the requester owes us that
    assign misalign = acc_valid && (acc_size != raw_align_pkg::SZ_BYTE) && acc_addr[0];
    // no read is issued in the cycle the stall is taken; the pending
    // register write must land first
    assign rd_go = acc_valid && !acc_write && !hazard;
    assign wr_go = acc_valid && acc_write && !misalign;

    byte_lane_steer u_steer (
        .size(acc_size),
        .addr_lsb(acc_addr[0]),
        .wdata(acc_wdata),
        .be(lane_be),
        .lane_wdata(lane_wdata),
        .rd_byte(s_q.rd_byte),
        .rd_hi(s_q.rd_hi),
        .mem_rdata(mem_rdata),
        .rdata(rd_sel)
    );

    // ============================================================
    // next state
    // ============================================================
    always_comb begin
        s_d = s_q;
        // one stall cycle per detected hazard
        s_d.stall = hazard;
        s_d.mem_re = rd_go;
        s_d.mem_we = wr_go;
        s_d.addr_err = misalign;
        if (rd_go || wr_go) begin
            // word reads from odd addresses fall back to the even word
            if (acc_size == raw_align_pkg::SZ_BYTE) begin
                s_d.mem_addr = acc_addr;
            end else begin
                s_d.mem_addr = {acc_addr[15:1], 1'b0};
            end
            s_d.mem_be = lane_be;
            s_d.mem_wdata = lane_wdata;
            s_d.rd_byte = (acc_size == raw_align_pkg::SZ_BYTE);
            s_d.rd_hi = (acc_size == raw_align_pkg::SZ_BYTE) && acc_addr[0];
        end
        // memory answers while the read strobe stands; the data is valid one cycle after the strobe
        s_d.rdata_valid = s_q.mem_re;
        if (s_q.mem_re) begin
            s_d.rdata = rd_sel;
        end
        // register write-back keeps the high byte in byte mode
        s_d.reg_we = reg_wr_valid;
        if (reg_wr_valid) begin
            if (reg_byte) begin
                s_d.reg_wdata = {reg_old[15:8], reg_result[7:0]};
            end else begin
                s_d.reg_wdata = reg_result;
            end
        end
        // flags follow the width of the operation
        if (alu_valid) begin
            if (alu_byte) begin
                s_d.flag_n = alu_result[7];
                s_d.flag_z = (alu_result[7:0] == 8'h00);
            end else begin
                s_d.flag_n = alu_result[15];
                s_d.flag_z = (alu_result == 16'h0000);
            end
        end
    end

    // ============================================================
    // state register
    // ============================================================
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // outputs, all straight from the state register
    // ============================================================
    // pc and pre-fetch freeze for the stall cycle only
    assign stall_q = s_q.stall;
    assign hold_pc_q = s_q.stall;
    assign hold_prefetch_q = s_q.stall;
    assign mem_addr_q = s_q.mem_addr;
    assign mem_be_q = s_q.mem_be;
    assign mem_we_q = s_q.mem_we;
    assign mem_re_q = s_q.mem_re;
    assign mem_wdata_q = s_q.mem_wdata;
    assign rdata_q = s_q.rdata;
    assign rdata_valid_q = s_q.rdata_valid;
    assign addr_err_q = s_q.addr_err;
    assign reg_we_q = s_q.reg_we;
    assign reg_wdata_q = s_q.reg_wdata;
    assign flag_n_q = s_q.flag_n;
    assign flag_z_q = s_q.flag_z;

    // ============================================================
    // checks
    // ============================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_stall_one_cycle: assert property (stall_q |=> !stall_q)
        else $error("stall lasted more than one cycle");

    chk_hazard_stalls: assert property (hazard |=> stall_q && hold_pc_q)
        else $error("detected hazard produced no stall");

    chk_direct_src_free: assert property (
        (pf_src_mode == raw_align_pkg::AM_DIRECT) && !stall_q |=> !stall_q)
        else $error("direct source operand caused a stall");

    chk_plain_ind_pair: assert property (
        detect_point && dst_live && !ex_is_call && pf_src_valid
        && (ex_dst_reg == pf_src_reg) && (ex_dst_mode == raw_align_pkg::AM_INDIRECT)
        && is_indirect(pf_src_mode) && !stall_q
        |=> stall_q == ($past(pf_src_reg_value) == wreg_map_addr($past(pf_src_reg))))
        else $error("indirect pair stall decision wrong");

    chk_exc_keeps_stall: assert property (hazard && exc_pending |=> stall_q)
        else $error("stall dropped before exception");

    chk_call_sp_stall: assert property (
        ex_last_cycle && !ex_is_window && ex_is_call && !ex_no_wreg_write && pf_src_valid
        && (pf_src_reg == raw_align_pkg::STACK_PTR_IDX) && is_indirect(pf_src_mode)
        && !stall_q |=> stall_q)
        else $error("call followed by stack pointer read did not stall");

    chk_jump_no_stall: assert property (ex_no_wreg_write && !stall_q |=> !stall_q)
        else $error("jump or return caused a stall");

    chk_window_second: assert property (
        ex_is_window && !ex_window_second && !stall_q |=> !stall_q)
        else $error("window access stalled outside its second cycle");

    chk_stall_no_read: assert property (stall_q |-> !mem_re_q && hold_prefetch_q)
        else $error("data read issued during stall");

    chk_misalign_wr: assert property (
        misalign && acc_write |=> !mem_we_q && addr_err_q)
        else $error("misaligned word write reached memory");

    chk_misalign_rd: assert property (
        misalign && !acc_write && !hazard
        |=> mem_re_q && !mem_addr_q[0] && addr_err_q ##1 rdata_valid_q)
        else $error("misaligned word read not completed at even address");

    chk_byte_reg_hi: assert property (
        reg_wr_valid && reg_byte |=> reg_we_q && (reg_wdata_q[15:8] == $past(reg_old[15:8])))
        else $error("byte register write disturbed high byte");

    chk_byte_flags: assert property (
        alu_valid && alu_byte
        |=> (flag_z_q == ($past(alu_result[7:0]) == 8'h00)) && (flag_n_q == $past(alu_result[7])))
        else $error("byte flags not taken from 8-bit result");

    chk_lane_select: assert property (
        acc_valid && acc_write && (acc_size == raw_align_pkg::SZ_BYTE)
        |=> mem_be_q == ($past(acc_addr[0]) ? 2'h2 : 2'h1))
        else $error("byte lane does not follow address bit 0");

endmodule
`default_nettype wire

// ==== xmem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// x data memory model, one word wide with two byte lanes
// ============================================================
module xmem_model (
    // clock
    input wire logic core_clk,
    // access from the block
    input wire logic [15:0] mem_addr_q,
    input wire logic [1:0] mem_be_q,
    input wire logic mem_we_q,
    input wire logic mem_re_q,
    input wire logic [15:0] mem_wdata_q,
    // read data
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [256];
    logic [15:0] last_q;
    // start cleared so the bench shadow copy agrees
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        last_q = 16'h0000;
    end
    // lane 0 holds the even byte, lane 1 the odd byte
    always @(posedge core_clk) begin
        if (mem_we_q && mem_be_q[0]) begin
            mem[mem_addr_q[8:1]][7:0] <= mem_wdata_q[7:0];
        end
        if (mem_we_q && mem_be_q[1]) begin
            mem[mem_addr_q[8:1]][15:8] <= mem_wdata_q[15:8];
        end
        last_q <= mem_rdata;
    end
    // valid only while the strobe stands; else a value that flips every cycle
    assign mem_rdata = mem_re_q ? mem[mem_addr_q[8:1]] : ~last_q;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk, rst, ex_dst_valid, ex_is_call, ex_no_wreg_write, ex_last_cycle;
    logic ex_is_window, ex_window_second, exc_pending, pf_src_valid, acc_valid, acc_write;
    logic reg_wr_valid, reg_byte, alu_valid, alu_byte, alu_p;
    logic [3:0] ex_dst_reg, pf_src_reg;
    logic [15:0] pf_src_reg_value, acc_addr, acc_wdata, mem_rdata, reg_old, reg_result;
    logic [15:0] alu_result, mem_addr_q, mem_wdata_q, rdata_q, reg_wdata_q;
    logic [1:0] mem_be_q;
    logic stall_q, hold_pc_q, hold_prefetch_q, mem_we_q, mem_re_q, rdata_valid_q;
    logic addr_err_q, reg_we_q, flag_n_q, flag_z_q;
    raw_align_pkg::addr_mode_t ex_dst_mode, pf_src_mode;
    raw_align_pkg::acc_size_t acc_size;
    logic [15:0] shadow [256];
    logic [15:0] st_q[$], rd_q[$], er_q[$], rg_q[$], fl_q[$];
    logic [31:0] r;
    int seed, err_total, cmp_count;

    raw_stall_align raw_stall_align_i (
        .core_clk(core_clk), .rst(rst), .ex_dst_valid(ex_dst_valid), .ex_dst_reg(ex_dst_reg),
        .ex_dst_mode(ex_dst_mode), .ex_is_call(ex_is_call), .ex_no_wreg_write(ex_no_wreg_write),
        .ex_last_cycle(ex_last_cycle), .ex_is_window(ex_is_window),
        .ex_window_second(ex_window_second), .exc_pending(exc_pending),
        .pf_src_valid(pf_src_valid), .pf_src_reg(pf_src_reg), .pf_src_mode(pf_src_mode),
        .pf_src_reg_value(pf_src_reg_value), .stall_q(stall_q), .hold_pc_q(hold_pc_q),
        .hold_prefetch_q(hold_prefetch_q), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_size(acc_size), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .mem_addr_q(mem_addr_q), .mem_be_q(mem_be_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q),
        .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .rdata_q(rdata_q),
        .rdata_valid_q(rdata_valid_q), .addr_err_q(addr_err_q), .reg_wr_valid(reg_wr_valid),
        .reg_byte(reg_byte), .reg_old(reg_old), .reg_result(reg_result), .reg_we_q(reg_we_q),
        .reg_wdata_q(reg_wdata_q), .alu_valid(alu_valid), .alu_byte(alu_byte),
        .alu_result(alu_result), .flag_n_q(flag_n_q), .flag_z_q(flag_z_q)
    );
    xmem_model xmem_model_i (
        .core_clk(core_clk), .mem_addr_q(mem_addr_q), .mem_be_q(mem_be_q), .mem_we_q(mem_we_q),
        .mem_re_q(mem_re_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata)
    );

    // ============================================================
    // clock, comparisons and closing
    // ============================================================
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // an empty queue yields unknown, so an unexpected result never matches
    function automatic logic [15:0] pop(ref logic [15:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 16'hXXXX;
    endfunction
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_stall(input logic [15:0] g, input logic [15:0] e);
        check(g, e);
    endtask
    task automatic cmp_data(input logic [15:0] g, input logic [15:0] e);
        check(g, e);
    endtask
    task automatic cmp_reg(input logic [15:0] g, input logic [15:0] e);
        check(g, e);
    endtask
    task automatic end_sim();
        if (st_q.size() + rd_q.size() + er_q.size() + rg_q.size() + fl_q.size() > 0) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, 16'h0000, 16'h0001);
        end
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watcher: outputs are settled at the falling edge
    always @(posedge core_clk) alu_p <= alu_valid && !rst;
    always @(negedge core_clk) begin
        if (!rst && (stall_q || hold_pc_q || hold_prefetch_q)) begin
            cmp_stall({13'h0000, stall_q, hold_pc_q, hold_prefetch_q}, pop(st_q));
        end
        if (!rst && rdata_valid_q) cmp_data(rdata_q, pop(rd_q));
        if (!rst && addr_err_q) cmp_data(16'h0001, pop(er_q));
        if (!rst && reg_we_q) cmp_reg(reg_wdata_q, pop(rg_q));
        if (alu_p) cmp_reg({14'h0000, flag_n_q, flag_z_q}, pop(fl_q));
    end
    initial begin
        #(25 * 8000);
        err_total++;
        end_sim();
    end

    // ============================================================
    // drivers
    // ============================================================
    task automatic idle();
        {ex_dst_valid, ex_is_call, ex_no_wreg_write, ex_last_cycle, ex_is_window} = '0;
        {ex_window_second, pf_src_valid, acc_valid, reg_wr_valid, alu_valid} = '0;
    endtask
    // one decision cycle then a two-cycle gap, keeping stalls three cycles apart
    task automatic hazard(input logic [1:0] dm, input logic [1:0] sm, input logic [3:0] dr,
        input logic [3:0] sr, input logic [15:0] v, input logic call, input logic nowr,
        input logic [1:0] win, input logic rd);
        logic exp;
        // win: bit 0 marks a window access, bit 1 its second cycle
        exp = !nowr && win != 2'h1 && sm[1] && (call ? sr == 4'hF : dm != 2'h0 && dr == sr
            && (dm != 2'h2 || v == {11'h000, dr, 1'b0}));
        @(negedge core_clk);
        {ex_dst_valid, ex_dst_reg, ex_is_call, ex_no_wreg_write} = {dm != 2'h0 && !call, dr, call, nowr};
        {ex_is_window, ex_window_second, ex_last_cycle} = {win[0], win[1], !win[0]};
        {pf_src_valid, pf_src_reg, pf_src_reg_value} = {sm != 2'h0, sr, v};
        ex_dst_mode = raw_align_pkg::addr_mode_t'(dm);
        pf_src_mode = raw_align_pkg::addr_mode_t'(sm);
        exc_pending = 1'($random(seed));
        {acc_valid, acc_write, acc_addr} = {rd, 1'b0, 16'h1000};
        acc_size = raw_align_pkg::SZ_WORD;
        if (rd && !exp) rd_q.push_back(shadow[0]);
        if (exp) st_q.push_back(16'h0007);
        @(negedge core_clk);
        idle();
        @(negedge core_clk);
    endtask
    // one access per cycle; the shadow copy follows the documented effect
    task automatic acc(input logic wr, input raw_align_pkg::acc_size_t sz, input logic [15:0] a,
        input logic [15:0] d);
        logic [7:0] i;
        logic mis;
        i = a[8:1];
        mis = sz != raw_align_pkg::SZ_BYTE && a[0];
        @(negedge core_clk);
        {acc_valid, acc_write, acc_addr, acc_wdata} = {1'b1, wr, a, d};
        acc_size = sz;
        if (mis) er_q.push_back(16'h0001);
        if (wr && !mis && sz != raw_align_pkg::SZ_BYTE) shadow[i] = d;
        else if (wr && sz == raw_align_pkg::SZ_BYTE && a[0]) shadow[i][15:8] = d[7:0];
        else if (wr && sz == raw_align_pkg::SZ_BYTE) shadow[i][7:0] = d[7:0];
        if (!wr && sz == raw_align_pkg::SZ_BYTE) rd_q.push_back(a[0] ? shadow[i] >> 8 : shadow[i] & 16'h00FF);
        else if (!wr) rd_q.push_back(shadow[i]);
    endtask
    // register write-back and flag updates ride alongside the accesses
    task automatic misc();
        {reg_wr_valid, reg_byte, alu_valid, alu_byte} = 4'($random(seed));
        {reg_old, reg_result} = $random(seed);
        alu_result = 16'($random(seed)) & (r[5] ? 16'hFFFF : 16'hFF00);
        if (reg_wr_valid) rg_q.push_back(reg_byte ? {reg_old[15:8], reg_result[7:0]} : reg_result);
        if (alu_valid && alu_byte) fl_q.push_back({alu_result[7], alu_result[7:0] == 8'h00});
        if (alu_valid && !alu_byte) fl_q.push_back({alu_result[15], alu_result == 16'h0000});
    endtask

    // ============================================================
    // test sequence
    // ============================================================
    initial begin
        {seed, err_total, cmp_count} = {32'hCD977EE1, 64'h0};
        foreach (shadow[i]) shadow[i] = 16'h0000;
        {rst, exc_pending, ex_dst_reg, pf_src_reg, pf_src_reg_value, acc_write, acc_addr} = {1'b1, 42'h0};
        {acc_wdata, reg_byte, reg_old, reg_result, alu_byte, alu_result, r} = '0;
        ex_dst_mode = raw_align_pkg::AM_NONE;
        pf_src_mode = raw_align_pkg::AM_NONE;
        acc_size = raw_align_pkg::SZ_BYTE;
        idle();
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        // every mode pair, pointer value equal and not equal to its own mapped address
        for (int k = 0; k < 32; k++) begin
            r = k;
            hazard(r[1:0], r[3:2], 4'h2, 4'h2, r[4] ? 16'h0004 : 16'h1234, 0, 0, 0, 0);
        end
        hazard(2'h0, 2'h3, 4'h0, 4'hF, 16'h0800, 1, 0, 0, 0);
        hazard(2'h1, 2'h2, 4'h5, 4'h5, 16'h0000, 0, 1, 0, 0);
        hazard(2'h1, 2'h2, 4'h5, 4'h5, 16'h0000, 0, 0, 2'h3, 0);
        hazard(2'h1, 2'h2, 4'h5, 4'h5, 16'h0000, 0, 0, 2'h1, 0);
        hazard(2'h1, 2'h2, 4'h3, 4'h3, 16'h0000, 0, 0, 0, 1);
        for (int k = 0; k < 120; k++) begin
            r = $random(seed);
            hazard(r[1:0], r[3:2], r[7:4], r[8] ? r[7:4] : r[12:9],
                r[13] ? {11'h000, r[7:4], 1'b0} : r[31:16], r[16:14] == 3'h0,
                r[19:17] == 3'h0, r[21:20], 1'b0);
        end
        $display("stall tests done");
        acc(1, raw_align_pkg::SZ_WORD, 16'h1000, 16'h1234);
        acc(1, raw_align_pkg::SZ_BYTE, 16'h1001, 16'h0034);
        acc(0, raw_align_pkg::SZ_WORD, 16'h1001, 16'h0000);
        acc(1, raw_align_pkg::SZ_WORD, 16'h1003, 16'hBEEF);
        acc(1, raw_align_pkg::SZ_DWORD, 16'h1005, 16'hCAFE);
        acc(0, raw_align_pkg::SZ_DWORD, 16'h1002, 16'h0000);
        acc(0, raw_align_pkg::SZ_BYTE, 16'h1001, 16'h0000);
        for (int k = 0; k < 200; k++) begin
            r = $random(seed);
            acc(r[0], raw_align_pkg::acc_size_t'(r[2:1] % 2'h3), {10'h040, r[8:3]}, r[31:16]);
            misc();
        end
        // let the last access be sampled before the bus goes quiet
        @(negedge core_clk);
        idle();
        repeat (4) @(negedge core_clk);
        $display("data tests done");
        end_sim();
    end
endmodule
`default_nettype wire
